// File: ssr_pkg.sv
// Shared constants and carrier types for the instrument status reporting block.
// Assumes one clock domain and a host command port already decoded into register selects.
package ssr_pkg;

  localparam int SSR_GROUP_WIDTH = 16;
  localparam int SSR_BYTE_WIDTH = 8;
  localparam int SSR_GROUP_COUNT = 2;

  // Group indexes of the SCPI register groups
  localparam int SSR_GRP_QUES = 0;
  localparam int SSR_GRP_OPER = 1;

  // Bit 15 of every 16-bit part is forced to zero
  localparam logic [15:0] SSR_GROUP_MASK = 16'h7fff;

  localparam logic [15:0] SSR_PTR_RESET = 16'h7fff;
  localparam logic [15:0] SSR_NTR_RESET = 16'h0000;
  localparam logic [15:0] SSR_ENABLE_RESET = 16'h0000;
  localparam logic [15:0] SSR_EVENT_RESET = 16'h0000;
  localparam logic [15:0] SSR_COND_RESET = 16'h0000;
  localparam logic [7:0] SSR_SRE_RESET = 8'h00;
  localparam logic [7:0] SSR_ESE_RESET = 8'h00;
  localparam logic [7:0] SSR_ESR_RESET = 8'h00;
  localparam logic [7:0] SSR_STB_RESET = 8'h00;

  // Status byte bit positions
  localparam int SSR_STB_ERRQ = 2;
  localparam int SSR_STB_QUES = 3;
  localparam int SSR_STB_MAV = 4;
  localparam int SSR_STB_ESB = 5;
  localparam int SSR_STB_MSS = 6;
  localparam int SSR_STB_OPER = 7;
  // Bits 0, 1 unused and bit 6 never qualifies a request
  localparam logic [7:0] SSR_STB_REQ_MASK = 8'hbc;
  localparam logic [7:0] SSR_ZERO_BYTE = 8'h00;
  localparam logic [15:0] SSR_ZERO_WORD = 16'h0000;

  typedef enum logic [1:0] {
    SSR_TGT_COMMON,
    SSR_TGT_QUES,
    SSR_TGT_OPER,
    SSR_TGT_NONE
  } ssr_target_type;

  // Parts of a SCPI group, or the common registers when target is common
  typedef enum logic [2:0] {
    SSR_PART_COND,
    SSR_PART_PTR,
    SSR_PART_NTR,
    SSR_PART_EVENT,
    SSR_PART_ENABLE,
    SSR_PART_STB,
    SSR_PART_SRE,
    SSR_PART_ESE
  } ssr_part_type;

  // Common ESR read uses target common with part event
  typedef struct packed {
    logic valid;
    logic write;
    ssr_target_type target;
    ssr_part_type part;
    logic [15:0] wdata;
  } ssr_cmd_type;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } ssr_rsp_type;

endpackage : ssr_pkg

// File: ssr_group.sv
// One 16-bit SCPI status group: condition, two transition filters, event latch, enable.
// Assumes the parent hands it one-cycle read and write strobes already decoded to this group, with the part alongside.
`timescale 1ns/1ps
module ssr_group
  import ssr_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [15:0] cond_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire ssr_part_type part_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o,
  output logic summary_o
);

  typedef struct packed {
    logic [15:0] cond;
    logic [15:0] ptr;
    logic [15:0] falling_transition_filter;
    logic [15:0] evt;
    logic [15:0] en;
  } ssr_group_state_type;

  ssr_group_state_type state_reg;
  ssr_group_state_type state_next;
  logic [15:0] rise;
  logic [15:0] fall;

  always_comb begin
    state_next = state_reg;
    state_next.cond = cond_i & SSR_GROUP_MASK;
    rise = state_next.cond & ~state_reg.cond & state_reg.ptr;
    fall = ~state_next.cond & state_reg.cond & state_reg.falling_transition_filter;
    if (wr_i && part_i == SSR_PART_PTR) begin
      state_next.ptr = wdata_i & SSR_GROUP_MASK;
    end
    if (wr_i && part_i == SSR_PART_NTR) begin
      state_next.falling_transition_filter = wdata_i & SSR_GROUP_MASK;
    end
    if (wr_i && part_i == SSR_PART_ENABLE) begin
      state_next.en = wdata_i & SSR_GROUP_MASK;
    end
    // New transitions are merged after the clear so none is lost
    if (rd_i && part_i == SSR_PART_EVENT) begin
      state_next.evt = SSR_EVENT_RESET;
    end
    state_next.evt = state_next.evt | rise | fall;
  end

  always_comb begin
    case (part_i)
      SSR_PART_COND: rdata_o = state_reg.cond;
      SSR_PART_PTR: rdata_o = state_reg.ptr;
      SSR_PART_NTR: rdata_o = state_reg.falling_transition_filter;
      SSR_PART_EVENT: rdata_o = state_reg.evt;
      SSR_PART_ENABLE: rdata_o = state_reg.en;
      default: rdata_o = SSR_ZERO_WORD;
    endcase
  end

  assign summary_o = |(state_reg.evt & state_reg.en);

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      state_reg.cond <= SSR_COND_RESET;
      state_reg.ptr <= SSR_PTR_RESET;
      state_reg.falling_transition_filter <= SSR_NTR_RESET;
      state_reg.evt <= SSR_EVENT_RESET;
      state_reg.en <= SSR_ENABLE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : ssr_group

// File: ssr_status.sv
// Top of the status reporting block: two SCPI groups, event status byte, status byte,
// service request enable and service request output.
// Assumes the host command decoder presents one command per cycle on cmd_i.
`timescale 1ns/1ps
// Functional notes
// - Five 16-bit parts share bit positions
// - Bit 15 of every part reads zero
// - Condition follows inputs, read-only, not cleared
// - Rising edge sets event when positive filter set
// - Falling edge sets event when negative filter set
// - Transition filters read/write, reads harmless
// - Events latch until read, read clears
// - Summary is OR of event AND enable
// - Enable part read/write, not cleared
// - Group summary feeds next level condition
// - Status byte bit 6 is master summary
// - Status byte readable by query and poll
// - Request enable per bit, bit 6 ignored
// - Enabled status bit rising raises service request
// - Request enable written and read back
// - Bit 2 flags error queue not empty
// - Bit 3 is questionable group summary
// - Bit 4 flags message available
// - Bit 5 is event status summary
// - Bit 7 is operation group summary
// - Message available from output buffer state
// - Enabled event status rise sets bit 5
module ssr_status
  import ssr_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire ssr_cmd_type cmd_i,
  input wire logic [15:0] ques_cond_i,
  input wire logic [15:0] oper_cond_i,
  input wire logic [7:0] esr_set_i,
  input wire logic err_queue_nonempty_i,
  input wire logic out_buffer_nonempty_i,
  input wire logic serial_poll_i,
  output ssr_rsp_type rsp_o,
  output logic [7:0] status_byte_o,
  output logic srq_o
);

  typedef struct packed {
    logic [7:0] service_request_enable;
    logic [7:0] ese;
    logic [7:0] esr;
    logic [7:0] stb;
    logic srq;
    ssr_rsp_type rsp;
  } ssr_top_state_type;

  ssr_top_state_type state_reg;
  ssr_top_state_type state_next;
  logic [15:0] grp_cond [SSR_GROUP_COUNT];
  logic [15:0] grp_rdata [SSR_GROUP_COUNT];
  logic [SSR_GROUP_COUNT-1:0] grp_summary;
  logic [SSR_GROUP_COUNT-1:0] grp_wr;
  logic [SSR_GROUP_COUNT-1:0] grp_rd;
  logic [7:0] stb_raw;
  logic [7:0] req_bits;
  logic [7:0] req_bits_prev;
  logic esb;

  // True when the command addresses the given target and part
  function automatic logic cmd_hit(input ssr_cmd_type c, input ssr_target_type t,
                                   input ssr_part_type p);
    cmd_hit = c.valid && c.target == t && c.part == p;
  endfunction : cmd_hit

  function automatic ssr_target_type grp_target(input int g);
    grp_target = (g == SSR_GRP_QUES) ? SSR_TGT_QUES : SSR_TGT_OPER;
  endfunction : grp_target

  assign grp_cond[SSR_GRP_QUES] = ques_cond_i;
  assign grp_cond[SSR_GRP_OPER] = oper_cond_i;

  genvar gi;
  generate
    for (gi = 0; gi < SSR_GROUP_COUNT; gi++) begin : g_group
      assign grp_wr[gi] = cmd_i.valid && cmd_i.write && cmd_i.target == grp_target(gi);
      assign grp_rd[gi] = cmd_i.valid && !cmd_i.write && cmd_i.target == grp_target(gi);
      ssr_group u_group (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .cond_i(grp_cond[gi]),
        .wr_i(grp_wr[gi]),
        .rd_i(grp_rd[gi]),
        .part_i(cmd_i.part),
        .wdata_i(cmd_i.wdata),
        .rdata_o(grp_rdata[gi]),
        .summary_o(grp_summary[gi])
      );
    end
  endgenerate

  // Event status summary; a level on enabled latched bits covers each 0-to-1 rise
  assign esb = |(state_reg.esr & state_reg.ese);

  always_comb begin
    stb_raw = SSR_ZERO_BYTE;
    stb_raw[SSR_STB_ERRQ] = err_queue_nonempty_i;
    stb_raw[SSR_STB_QUES] = grp_summary[SSR_GRP_QUES];
    stb_raw[SSR_STB_MAV] = out_buffer_nonempty_i;
    stb_raw[SSR_STB_ESB] = esb;
    stb_raw[SSR_STB_OPER] = grp_summary[SSR_GRP_OPER];
    req_bits = stb_raw & state_reg.service_request_enable & SSR_STB_REQ_MASK;
    stb_raw[SSR_STB_MSS] = |req_bits;
  end

  // Previous qualified bits, taken from the registered byte for edge detection
  assign req_bits_prev = state_reg.stb & state_reg.service_request_enable & SSR_STB_REQ_MASK;

  always_comb begin
    state_next = state_reg;
    state_next.stb = stb_raw;
    state_next.rsp.valid = 1'b0;
    state_next.rsp.data = SSR_ZERO_WORD;
    if (cmd_hit(cmd_i, SSR_TGT_COMMON, SSR_PART_SRE) && cmd_i.write) begin
      state_next.service_request_enable = cmd_i.wdata[7:0];
    end
    if (cmd_hit(cmd_i, SSR_TGT_COMMON, SSR_PART_ESE) && cmd_i.write) begin
      state_next.ese = cmd_i.wdata[7:0];
    end
    if (cmd_hit(cmd_i, SSR_TGT_COMMON, SSR_PART_EVENT) && !cmd_i.write) begin
      state_next.esr = SSR_ESR_RESET;
    end
    // Set wins over the read clear
    state_next.esr = state_next.esr | esr_set_i;
    if (cmd_i.valid && !cmd_i.write) begin
      state_next.rsp.valid = 1'b1;
      case (cmd_i.target)
        SSR_TGT_COMMON: begin
          case (cmd_i.part)
            SSR_PART_STB: state_next.rsp.data = {SSR_ZERO_BYTE, state_reg.stb};
            SSR_PART_SRE: state_next.rsp.data = {SSR_ZERO_BYTE, state_reg.service_request_enable};
            SSR_PART_ESE: state_next.rsp.data = {SSR_ZERO_BYTE, state_reg.ese};
            SSR_PART_EVENT: state_next.rsp.data = {SSR_ZERO_BYTE, state_reg.esr};
            default: state_next.rsp.data = SSR_ZERO_WORD;
          endcase
        end
        SSR_TGT_QUES: state_next.rsp.data = grp_rdata[SSR_GRP_QUES];
        SSR_TGT_OPER: state_next.rsp.data = grp_rdata[SSR_GRP_OPER];
        default: state_next.rsp.data = SSR_ZERO_WORD;
      endcase
    end else if (serial_poll_i) begin
      state_next.rsp.valid = 1'b1;
      state_next.rsp.data = {SSR_ZERO_BYTE, state_reg.stb};
    end
    // Request held until the controller polls; a fresh rise in that cycle still wins
    if (serial_poll_i) begin
      state_next.srq = 1'b0;
    end
    if (|(req_bits & ~req_bits_prev)) begin
      state_next.srq = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      state_reg.service_request_enable <= SSR_SRE_RESET;
      state_reg.ese <= SSR_ESE_RESET;
      state_reg.esr <= SSR_ESR_RESET;
      state_reg.stb <= SSR_STB_RESET;
      state_reg.srq <= 1'b0;
      state_reg.rsp.valid <= 1'b0;
      state_reg.rsp.data <= SSR_ZERO_WORD;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rsp_o = state_reg.rsp;
  assign status_byte_o = state_reg.stb;
  assign srq_o = state_reg.srq;

endmodule : ssr_status

// File: ssr_status_assertions.sv
// Port checks for the status block: answers, status byte bits, request line.
// Assumes it is bound to ssr_status and sees only that module's ports.
`timescale 1ns/1ps
module ssr_status_assertions
  import ssr_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire ssr_cmd_type cmd_i,
  input wire logic [15:0] ques_cond_i,
  input wire logic [15:0] oper_cond_i,
  input wire logic [7:0] esr_set_i,
  input wire logic err_queue_nonempty_i,
  input wire logic out_buffer_nonempty_i,
  input wire logic serial_poll_i,
  input wire ssr_rsp_type rsp_o,
  input wire logic [7:0] status_byte_o,
  input wire logic srq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // Mask shadow; a read in the same cycle as its write is not covered
  logic [7:0] sre_reg;
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      sre_reg <= SSR_SRE_RESET;
    end else if (cmd_i.valid && cmd_i.write && cmd_i.target == SSR_TGT_COMMON
                 && cmd_i.part == SSR_PART_SRE) begin
      sre_reg <= cmd_i.wdata[7:0];
    end
  end
  sequence s_read;
    cmd_i.valid && !cmd_i.write;
  endsequence
  sequence s_sre_read;
    s_read ##0 (cmd_i.target == SSR_TGT_COMMON && cmd_i.part == SSR_PART_SRE);
  endsequence
  a_read_answer: assert property (s_read |=> rsp_o.valid) else $error("read unanswered");
  a_bit15_zero: assert property (rsp_o.valid |-> !rsp_o.data[15]) else $error("bit 15 set");
  a_sre_back: assert property (s_sre_read |=> rsp_o.data == {8'h00, sre_reg})
    else $error("mask readback wrong");
  a_err_follow: assert property (
    $past(rstn_i) |-> status_byte_o[2] == $past(err_queue_nonempty_i))
    else $error("queue bit wrong");
  a_mav_follow: assert property (
    $past(rstn_i) |-> status_byte_o[4] == $past(out_buffer_nonempty_i))
    else $error("message bit wrong");
  a_low_bits: assert property (status_byte_o[1:0] == 2'b00) else $error("unused bits set");
  // The byte was formed with the mask as it stood one cycle earlier
  a_srq_raise: assert property (
    |(status_byte_o & ~$past(status_byte_o) & $past(sre_reg) & SSR_STB_REQ_MASK)
    |-> ##[0:1] srq_o) else $error("request not raised");
  a_srq_hold: assert property (srq_o && !serial_poll_i |=> srq_o) else $error("request dropped");
  a_master_summary: assert property (
    status_byte_o[6] == |(status_byte_o & $past(sre_reg) & SSR_STB_REQ_MASK))
    else $error("master summary wrong");
endmodule : ssr_status_assertions

// File: ssr_host_model.sv
// Remote host model: issues decoded commands and serial polls, one at a time.
// Assumes read answers appear just after the edge that takes the command.
`timescale 1ns/1ps
module ssr_host_model
  import ssr_pkg::*;
(
  input wire logic clock_i,
  input wire ssr_rsp_type rsp_i,
  output ssr_cmd_type cmd_o,
  output logic serial_poll_o
);
  initial begin
    cmd_o = '0;
    serial_poll_o = 1'b0;
  end
  // A missing answer returns a marker so it can never pass for data
  task automatic access(input logic wr, input ssr_target_type t, input ssr_part_type p,
                        input logic [15:0] wd, output logic [15:0] rd);
    @(posedge clock_i);
    #1 cmd_o = '{valid: 1'b1, write: wr, target: t, part: p, wdata: wd};
    @(posedge clock_i);
    #1 cmd_o = '0;
    rd = rsp_i.valid ? rsp_i.data : 16'hdead;
  endtask : access
  task automatic poll(output logic [15:0] rd);
    @(posedge clock_i);
    #1 serial_poll_o = 1'b1;
    @(posedge clock_i);
    #1 serial_poll_o = 1'b0;
    rd = rsp_i.valid ? rsp_i.data : 16'hdead;
  endtask : poll
endmodule : ssr_host_model

// File: test_ssr_status.sv
// Self-checking bench for the status block, driving it through the host model.
// Assumes a 50 MHz clock and synchronous active-low reset.
`timescale 1ns/1ps
module test_ssr_status;
  import ssr_pkg::*;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [15:0] ques_cond_i = 16'h0000;
  logic [15:0] oper_cond_i = 16'h0000;
  logic [7:0] esr_set_i = 8'h00;
  logic err_queue_nonempty_i = 1'b0;
  logic out_buffer_nonempty_i = 1'b0;
  ssr_cmd_type cmd;
  ssr_rsp_type rsp;
  logic poll;
  logic [7:0] stb;
  logic srq;
  logic [15:0] rd;
  logic [7:0] src_bit [5] = '{8'h08, 8'h80, 8'h04, 8'h10, 8'h20};
  int n_errors = 0;
  int samples_checked = 0;
  initial forever #10 clock_i = ~clock_i;
  ssr_status u_dut (.clock_i(clock_i), .rstn_i(rstn_i), .cmd_i(cmd), .ques_cond_i(ques_cond_i),
    .oper_cond_i(oper_cond_i), .esr_set_i(esr_set_i), .err_queue_nonempty_i(err_queue_nonempty_i),
    .out_buffer_nonempty_i(out_buffer_nonempty_i), .serial_poll_i(poll), .rsp_o(rsp),
    .status_byte_o(stb), .srq_o(srq));
  ssr_host_model u_host (.clock_i(clock_i), .rsp_i(rsp), .cmd_o(cmd), .serial_poll_o(poll));
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t word got %h exp %h", $time, got, exp);
    end
  endtask : check_word
  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t flag got %b exp %b", $time, got, exp);
    end
  endtask : check_bit
  task automatic rc(input ssr_target_type t, input ssr_part_type p, input logic [15:0] e);
    u_host.access(1'b0, t, p, 16'h0000, rd);
    check_word(rd, e);
  endtask : rc
  task automatic wr(input ssr_target_type t, input ssr_part_type p, input logic [15:0] d);
    u_host.access(1'b1, t, p, d, rd);
  endtask : wr
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : step
  task automatic summarize();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
  initial begin
    step(12);
    rstn_i = 1'b1;
    rc(SSR_TGT_QUES, SSR_PART_PTR, 16'h7fff);
    rc(SSR_TGT_OPER, SSR_PART_NTR, 16'h0000);
    rc(SSR_TGT_QUES, SSR_PART_ENABLE, 16'h0000);
    rc(SSR_TGT_COMMON, SSR_PART_SRE, 16'h0000);
    wr(SSR_TGT_QUES, SSR_PART_NTR, 16'hffff);
    rc(SSR_TGT_QUES, SSR_PART_NTR, 16'h7fff);
    rc(SSR_TGT_QUES, SSR_PART_NTR, 16'h7fff);
    ques_cond_i = 16'h8008;
    step(3);
    wr(SSR_TGT_QUES, SSR_PART_COND, 16'h0000);
    rc(SSR_TGT_QUES, SSR_PART_COND, 16'h0008);
    rc(SSR_TGT_QUES, SSR_PART_COND, 16'h0008);
    rc(SSR_TGT_QUES, SSR_PART_EVENT, 16'h0008);
    rc(SSR_TGT_QUES, SSR_PART_EVENT, 16'h0000);
    ques_cond_i = 16'h0000;
    step(3);
    rc(SSR_TGT_QUES, SSR_PART_EVENT, 16'h0008);
    wr(SSR_TGT_QUES, SSR_PART_NTR, 16'h0000);
    wr(SSR_TGT_QUES, SSR_PART_PTR, 16'h0001);
    ques_cond_i = 16'h0009;
    step(3);
    rc(SSR_TGT_QUES, SSR_PART_EVENT, 16'h0001);
    ques_cond_i = 16'h0000;
    step(3);
    rc(SSR_TGT_QUES, SSR_PART_EVENT, 16'h0000);
    wr(SSR_TGT_QUES, SSR_PART_ENABLE, 16'h0001);
    rc(SSR_TGT_QUES, SSR_PART_ENABLE, 16'h0001);
    wr(SSR_TGT_OPER, SSR_PART_ENABLE, 16'h0001);
    wr(SSR_TGT_COMMON, SSR_PART_ESE, 16'h0001);
    wr(SSR_TGT_COMMON, SSR_PART_SRE, 16'h0040);
    err_queue_nonempty_i = 1'b1;
    step(4);
    check_word({8'h00, stb}, 16'h0004);
    check_bit(srq, 1'b0);
    err_queue_nonempty_i = 1'b0;
    wr(SSR_TGT_COMMON, SSR_PART_SRE, 16'hffbc);
    rc(SSR_TGT_COMMON, SSR_PART_SRE, 16'h00bc);
    for (int i = 0; i < 5; i++) begin
      ques_cond_i[0] = (i == 0);
      oper_cond_i[0] = (i == 1);
      err_queue_nonempty_i = (i == 2);
      out_buffer_nonempty_i = (i == 3);
      esr_set_i[0] = (i == 4);
      step(1);
      esr_set_i = 8'h00;
      step(3);
      check_word({8'h00, stb}, {8'h00, src_bit[i] | 8'h40});
      check_bit(srq, 1'b1);
      rc(SSR_TGT_COMMON, SSR_PART_STB, {8'h00, src_bit[i] | 8'h40});
      u_host.poll(rd);
      check_word(rd, {8'h00, src_bit[i] | 8'h40});
      check_bit(srq, 1'b0);
      ques_cond_i = 16'h0000;
      oper_cond_i = 16'h0000;
      err_queue_nonempty_i = 1'b0;
      out_buffer_nonempty_i = 1'b0;
      wr(SSR_TGT_QUES, SSR_PART_EVENT, 16'h0000);
      rc(SSR_TGT_QUES, SSR_PART_EVENT, {15'h0000, i == 0});
      rc(SSR_TGT_OPER, SSR_PART_EVENT, {15'h0000, i == 1});
      rc(SSR_TGT_COMMON, SSR_PART_EVENT, {15'h0000, i == 4});
      step(3);
    end
    // A rise taken at the very edge of a clearing read must survive it
    fork
      rc(SSR_TGT_QUES, SSR_PART_EVENT, 16'h0000);
      begin
        step(1);
        ques_cond_i = 16'h0001;
      end
    join
    rc(SSR_TGT_QUES, SSR_PART_EVENT, 16'h0001);
    fork
      rc(SSR_TGT_COMMON, SSR_PART_EVENT, 16'h0000);
      begin
        step(1);
        esr_set_i = 8'h02;
        step(1);
        esr_set_i = 8'h00;
      end
    join
    rc(SSR_TGT_COMMON, SSR_PART_EVENT, 16'h0002);
    step(3);
    check_word({8'h00, stb}, 16'h0000);
    summarize();
  end
  initial begin
    repeat (3000) @(posedge clock_i);
    n_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    summarize();
  end
endmodule : test_ssr_status
bind ssr_status ssr_status_assertions u_chk (.clock_i(clock_i), .rstn_i(rstn_i), .cmd_i(cmd_i),
  .ques_cond_i(ques_cond_i), .oper_cond_i(oper_cond_i), .esr_set_i(esr_set_i),
  .err_queue_nonempty_i(err_queue_nonempty_i), .out_buffer_nonempty_i(out_buffer_nonempty_i),
  .serial_poll_i(serial_poll_i), .rsp_o(rsp_o), .status_byte_o(status_byte_o), .srq_o(srq_o));
